/* File: rtl/sris_pkg.sv */
// shared constants for the system reset and interrupt sequencer
// assumes a single 125 MHz fast oscillator clock drives every register
package sris_pkg;

  localparam int SEQ_W = 13;

  // reset and stop sequencing lengths, in fast-clock cycles
  localparam logic [SEQ_W-1:0] LONG_CYCLES       = 13'h1000;
  localparam logic [SEQ_W-1:0] PIN_CYCLES        = 13'h0020;
  localparam logic [SEQ_W-1:0] HOLD_CYCLES       = 13'h0020;
  localparam logic [SEQ_W-1:0] TAIL_CYCLES       = 13'h0003;
  localparam logic [SEQ_W-1:0] STOP_LONG_CYCLES  = 13'h1000;
  localparam logic [SEQ_W-1:0] STOP_SHORT_CYCLES = 13'h0020;
  localparam logic [SEQ_W-1:0] SEQ_ONE           = 13'h0001;
  localparam logic [SEQ_W-1:0] SEQ_ZERO          = 13'h0000;

  // prescaler: 4080 cycles per watchdog tick; service keeps stages 4..0
  localparam logic [SEQ_W-1:0] PRESC_WRAP      = 13'h0ff0;
  localparam logic [SEQ_W-1:0] PRESC_KEEP_MASK = 13'h001f;

  // register byte offsets
  localparam logic [7:0] ADDR_CAUSE   = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_SERVICE = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_INT_EN  = 8'h10;

  // reset cause register bits
  localparam int CAUSE_POWER_ON  = 7;
  localparam int CAUSE_WATCHDOG  = 5;
  localparam int CAUSE_BAD_OP    = 4;
  localparam int CAUSE_BAD_FETCH = 3;
  localparam int CAUSE_LOW_VOLT  = 1;
  localparam logic [7:0] CAUSE_RESET_VAL = 8'h80;

  // control register bits
  localparam int CTRL_PIN_FUNC   = 0;
  localparam int CTRL_SHORT_STOP = 1;
  localparam int CTRL_BREAK_WD   = 2;
  localparam int CTRL_STOP_EN    = 3;
  localparam int CTRL_WD_EN      = 4;
  localparam logic [7:0] CTRL_RESET_VAL = 8'h00;

  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [2:0] {
    SRIS_RUN,
    SRIS_LONG,
    SRIS_PIN,
    SRIS_HOLD,
    SRIS_TAIL,
    SRIS_STOP,
    SRIS_STOP_REC
  } sris_state_t;

endpackage : sris_pkg

/* File: rtl/sris_prescaler.sv */
// free-running prescaler with a terminal stage that emits the watchdog tick
// assumes clear requests come from posedge logic of the same clock
`timescale 1ns/1ps
module sris_prescaler
  import sris_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clear_all,
  input  wire logic             clear_mid,
  output logic                  tick_q,
  output logic [SEQ_W-1:0]      count_q
);

  logic [SEQ_W-1:0] count_d;
  logic             tick_d;

  always_comb
  begin
    count_d = count_q + SEQ_ONE;
    tick_d  = 1'b0;
    if (clear_all)
    begin
      count_d = SEQ_ZERO;
    end
    else if (clear_mid)
    begin
      count_d = count_q & PRESC_KEEP_MASK;
    end
    else if (count_q == PRESC_WRAP - SEQ_ONE)
    begin
      // terminal stage: tick and restart
      count_d = SEQ_ZERO;
      tick_d  = 1'b1;
    end
  end

  // negedge keeps clears clear of the posedge logic
  always_ff @(negedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_q <= SEQ_ZERO;
      tick_q  <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

endmodule : sris_prescaler

/* File: rtl/sris_int_arbiter.sv */
// interrupt latch and priority arbiter; index 0 is the highest hardware source
// assumes cpu strobes are one-cycle pulses on hclk
`timescale 1ns/1ps
module sris_int_arbiter
  import sris_pkg::*;
#(
  parameter int NUM_IRQ = 8,
  parameter int VEC_W   = $clog2(NUM_IRQ + 1)
)
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic [NUM_IRQ-1:0] irq_req,
  input  wire logic [NUM_IRQ-1:0] irq_enable,
  input  wire logic               global_mask,
  input  wire logic               instr_boundary,
  input  wire logic               ret_done,
  input  wire logic               soft_req,
  input  wire logic               service_ack,
  output logic                    int_take_q,
  output logic [VEC_W-1:0]        vector_q,
  output logic                    stack_regs_q,
  output logic                    set_mask_q,
  output logic                    stack_index_high_q,
  output logic                    latched_q
);

  logic [NUM_IRQ-1:0] pend;
  logic [VEC_W-1:0]   best;
  logic               any_pend;
  logic               boundary;
  logic               mask_prev_q;
  logic               latched_d;
  logic               take_d;
  logic [VEC_W-1:0]   vector_d;

  assign pend     = irq_req & irq_enable;
  assign any_pend = |pend;
  // a request pending at return beats the next opcode
  assign boundary = instr_boundary | ret_done;

  always_comb
  begin
    best = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        best = VEC_W'(i + 1);
      end
    end
  end

  always_comb
  begin
    latched_d = latched_q;
    take_d    = 1'b0;
    vector_d  = vector_q;
    if (latched_q && (service_ack || (mask_prev_q && !global_mask)))
    begin
      latched_d = 1'b0;
    end
    else if (!latched_q && boundary)
    begin
      if (soft_req)
      begin
        // software request ignores the global mask
        latched_d = 1'b1;
        take_d    = 1'b1;
        vector_d  = '0;
      end
      else if (!global_mask && any_pend)
      begin
        latched_d = 1'b1;
        take_d    = 1'b1;
        vector_d  = best;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latched_q          <= 1'b0;
      int_take_q         <= 1'b0;
      vector_q           <= '0;
      stack_regs_q       <= 1'b0;
      set_mask_q         <= 1'b0;
      stack_index_high_q <= 1'b0;
      mask_prev_q        <= 1'b0;
    end
    else
    begin
      latched_q          <= latched_d;
      int_take_q         <= take_d;
      vector_q           <= vector_d;
      stack_regs_q       <= take_d;
      set_mask_q         <= take_d;
      stack_index_high_q <= 1'b0;
      mask_prev_q        <= global_mask;
    end
  end

endmodule : sris_int_arbiter

/* File: rtl/sris_top.sv */
// system reset sequencer, watchdog and interrupt latch with an ahb-lite slave
// assumes hclk is the fast clock; power and voltage inputs are asynchronous
// Notes on behaviour
// - long reset: pin low 4096 cycles before release proceeds
// - each internal reset drives the pin low 32 cycles
// - internal reset lasts 32+3 cycles past pin drive
// - recovery 4096+64+3 cycles for long resets, else 64+3
// - power-on: reset, oscillator on, clocks off 4096, release 64+3 later
// - power-on sets its cause flag
// - watchdog overflow resets and sets its flag
// - service write clears watchdog and prescaler stages 12 to 5
// - watchdog tick at least every 4096 minus 16 cycles
// - watchdog halted in monitor-mode break when break-disable set
// - bad opcode sets its flag and resets
// - stop with stop-enable clear is a bad opcode
// - only an opcode fetch from a hole resets
// - low voltage sets flag; pin low until 4096 cycles after recovery
// - prescaler: 12 stages plus a terminal stage giving the tick
// - prescaler advances on the falling edge
// - stop clears counter; recovery 32 cycles if short bit else 4096
// - pin reset leaves the prescaler alone; it runs freely
// - interrupt latch holds until serviced or mask cleared
// - hardware interrupt at boundary only if unmasked and enabled
// - highest priority first; pending at return taken before next opcode
// - software interrupt ignores mask; stacks, sets mask, not index-high
`timescale 1ns/1ps
module sris_top
  import sris_pkg::*;
#(
  parameter int NUM_IRQ = 8,
  parameter int WDOG_W  = 6,
  parameter int VEC_W   = $clog2(NUM_IRQ + 1)
)
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [1:0]              hresp,
  output logic [31:0]             hrdata,
  input  wire logic               power_up_reset_pulse,
  input  wire logic               low_voltage_in,
  input  wire logic               bad_opcode_strobe,
  input  wire logic               stop_instr_strobe,
  input  wire logic               wake_request,
  input  wire logic               fetch_is_opcode,
  input  wire logic               fetch_unmapped,
  input  wire logic               break_active,
  input  wire logic               monitor_mode,
  input  wire logic [NUM_IRQ-1:0] irq_req,
  input  wire logic               global_mask,
  input  wire logic               instr_boundary,
  input  wire logic               ret_done,
  input  wire logic               soft_req,
  input  wire logic               service_ack,
  output logic                    reset_pin_out,
  output logic                    reset_pin_oe,
  output logic                    internal_reset,
  output logic                    internal_bus_clocks_en,
  output logic                    osc_enable,
  output logic                    int_take,
  output logic [VEC_W-1:0]        int_vector,
  output logic                    stack_regs,
  output logic                    set_mask,
  output logic                    stack_index_high,
  output logic                    int_latched
);

  // synchronisers for the asynchronous sources
  logic por_m_q;
  logic por_s_q;
  logic lv_m_q;
  logic lv_s_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      por_m_q <= 1'b0;
      por_s_q <= 1'b0;
      lv_m_q  <= 1'b0;
      lv_s_q  <= 1'b0;
    end
    else
    begin
      por_m_q <= power_up_reset_pulse;
      por_s_q <= por_m_q;
      lv_m_q  <= low_voltage_in;
      lv_s_q  <= lv_m_q;
    end
  end

  // ahb-lite slave: zero wait states, always OKAY
  logic        wr_pend_q;
  logic        wr_pend_d;
  logic [7:0]  wr_addr_q;
  logic [7:0]  wr_addr_d;
  logic [31:0] hrdata_d;
  logic        addr_phase;
  logic [7:0]  cause_q;
  logic [7:0]  cause_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [NUM_IRQ-1:0] int_en_q;
  logic [NUM_IRQ-1:0] int_en_d;
  logic        service_wr;
  sris_state_t state_q;
  sris_state_t state_d;

  assign addr_phase = hsel && htrans[1] && hready;
  assign service_wr = wr_pend_q && (wr_addr_q == ADDR_SERVICE);

  always_comb
  begin
    wr_pend_d = addr_phase && hwrite;
    wr_addr_d = addr_phase ? haddr[7:0] : wr_addr_q;
    hrdata_d  = hrdata;
    if (addr_phase && !hwrite)
    begin
      if (haddr[7:0] == ADDR_CAUSE)
      begin
        hrdata_d = 32'(cause_q);
      end
      else if (haddr[7:0] == ADDR_CONTROL)
      begin
        hrdata_d = 32'(ctrl_q);
      end
      else if (haddr[7:0] == ADDR_STATUS)
      begin
        hrdata_d = {24'h000000, 2'h0, int_latched, internal_bus_clocks_en,
                    internal_reset, 3'(state_q)};
      end
      else if (haddr[7:0] == ADDR_INT_EN)
      begin
        hrdata_d = 32'(int_en_q);
      end
      else
      begin
        hrdata_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // reset sources
  logic wd_ovf_q;
  logic ev_bad_op;
  logic ev_bad_fetch;
  logic ev_long;
  logic ev_short;
  logic in_run;

  assign in_run       = (state_q == SRIS_RUN);
  assign ev_bad_op    = in_run && (bad_opcode_strobe ||
                        (stop_instr_strobe && !ctrl_q[CTRL_STOP_EN]));
  // data accesses to holes are harmless
  assign ev_bad_fetch = in_run && fetch_is_opcode && fetch_unmapped;
  assign ev_long      = por_s_q || lv_s_q;
  assign ev_short     = ev_bad_op || ev_bad_fetch || (wd_ovf_q && in_run);

  always_comb
  begin
    cause_d = cause_q;
    ctrl_d  = ctrl_q;
    int_en_d = int_en_q;
    if (wr_pend_q && (wr_addr_q == ADDR_CAUSE))
    begin
      cause_d = cause_q & ~hwdata[7:0];
    end
    if (wr_pend_q && (wr_addr_q == ADDR_CONTROL))
    begin
      ctrl_d = hwdata[7:0];
    end
    if (wr_pend_q && (wr_addr_q == ADDR_INT_EN))
    begin
      int_en_d = hwdata[NUM_IRQ-1:0];
    end
    // hardware set beats a same-cycle clear
    if (por_s_q)
    begin
      cause_d = 8'h00;
      cause_d[CAUSE_POWER_ON] = 1'b1;
    end
    if (lv_s_q)
    begin
      cause_d[CAUSE_LOW_VOLT] = 1'b1;
    end
    if (wd_ovf_q && in_run)
    begin
      cause_d[CAUSE_WATCHDOG] = 1'b1;
    end
    if (ev_bad_op)
    begin
      cause_d[CAUSE_BAD_OP] = 1'b1;
    end
    if (ev_bad_fetch)
    begin
      cause_d[CAUSE_BAD_FETCH] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cause_q  <= CAUSE_RESET_VAL;
      ctrl_q   <= CTRL_RESET_VAL;
      int_en_q <= '0;
    end
    else
    begin
      cause_q  <= cause_d;
      ctrl_q   <= ctrl_d;
      int_en_q <= int_en_d;
    end
  end

  // sequencer
  logic [SEQ_W-1:0] cnt_q;
  logic [SEQ_W-1:0] cnt_d;
  logic [SEQ_W-1:0] stop_limit;
  logic             pin_drive_d;
  logic             pin_drive_q;
  logic             internal_reset_d;
  logic             clk_en_d;
  logic             osc_en_d;
  logic             presc_clear_all;
  logic             presc_tick;

  assign stop_limit = ctrl_q[CTRL_SHORT_STOP] ? STOP_SHORT_CYCLES
                                              : STOP_LONG_CYCLES;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q + SEQ_ONE;
    case (state_q)
      SRIS_RUN:
      begin
        cnt_d = SEQ_ZERO;
        if (stop_instr_strobe && ctrl_q[CTRL_STOP_EN])
        begin
          state_d = SRIS_STOP;
        end
      end
      SRIS_STOP:
      begin
        cnt_d = SEQ_ZERO;
        if (wake_request)
        begin
          state_d = SRIS_STOP_REC;
        end
      end
      SRIS_STOP_REC:
      begin
        if (cnt_q == stop_limit - SEQ_ONE)
        begin
          state_d = SRIS_RUN;
          cnt_d   = SEQ_ZERO;
        end
      end
      SRIS_LONG:
      begin
        if (lv_s_q)
        begin
          // count waits for the supply
          cnt_d = SEQ_ZERO;
        end
        else if (cnt_q == LONG_CYCLES - SEQ_ONE)
        begin
          state_d = SRIS_PIN;
          cnt_d   = SEQ_ZERO;
        end
      end
      SRIS_PIN:
      begin
        if (cnt_q == PIN_CYCLES - SEQ_ONE)
        begin
          state_d = SRIS_HOLD;
          cnt_d   = SEQ_ZERO;
        end
      end
      SRIS_HOLD:
      begin
        if (cnt_q == HOLD_CYCLES - SEQ_ONE)
        begin
          state_d = SRIS_TAIL;
          cnt_d   = SEQ_ZERO;
        end
      end
      SRIS_TAIL:
      begin
        if (cnt_q == TAIL_CYCLES - SEQ_ONE)
        begin
          state_d = SRIS_RUN;
          cnt_d   = SEQ_ZERO;
        end
      end
      default:
      begin
        state_d = SRIS_LONG;
        cnt_d   = SEQ_ZERO;
      end
    endcase
    if (ev_long)
    begin
      state_d = SRIS_LONG;
      cnt_d   = SEQ_ZERO;
    end
    else if (ev_short)
    begin
      state_d = SRIS_PIN;
      cnt_d   = SEQ_ZERO;
    end
  end

  always_comb
  begin
    pin_drive_d = (state_d == SRIS_LONG) || (state_d == SRIS_PIN);
    internal_reset_d      = (state_d == SRIS_LONG) || (state_d == SRIS_PIN) ||
                  (state_d == SRIS_HOLD) || (state_d == SRIS_TAIL);
    clk_en_d    = (state_d != SRIS_LONG) && (state_d != SRIS_STOP) &&
                  (state_d != SRIS_STOP_REC);
    osc_en_d    = (state_d != SRIS_STOP);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q                <= SRIS_LONG;
      cnt_q                  <= SEQ_ZERO;
      pin_drive_q            <= 1'b1;
      internal_reset         <= 1'b1;
      internal_bus_clocks_en <= 1'b0;
      osc_enable             <= 1'b1;
      reset_pin_out          <= 1'b0;
      reset_pin_oe           <= 1'b0;
    end
    else
    begin
      state_q                <= state_d;
      cnt_q                  <= cnt_d;
      pin_drive_q            <= pin_drive_d;
      internal_reset         <= internal_reset_d;
      internal_bus_clocks_en <= clk_en_d;
      osc_enable             <= osc_en_d;
      reset_pin_out          <= 1'b0;
      // pin stays an input until software enables its reset role
      reset_pin_oe           <= pin_drive_d && ctrl_d[CTRL_PIN_FUNC];
    end
  end

  // prescaler: cleared by internal resets and stop, not the pin
  assign presc_clear_all = ev_long || ev_short || (state_q == SRIS_STOP) ||
                           (in_run && stop_instr_strobe && ctrl_q[CTRL_STOP_EN]);

  sris_prescaler u_presc (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clear_all (presc_clear_all),
    .clear_mid (service_wr),
    .tick_q    (presc_tick),
    .count_q   ()
  );

  // watchdog counter on the prescaler tick
  logic [WDOG_W-1:0] wd_cnt_q;
  logic [WDOG_W-1:0] wd_cnt_d;
  logic              wd_ovf_d;
  logic              wd_run;
  logic              tick_prev_q;
  logic              tick_rise;

  assign tick_rise = presc_tick && !tick_prev_q;
  assign wd_run    = in_run && ctrl_q[CTRL_WD_EN] &&
                     !(break_active && monitor_mode && ctrl_q[CTRL_BREAK_WD]);

  always_comb
  begin
    wd_cnt_d = wd_cnt_q;
    wd_ovf_d = 1'b0;
    if (service_wr || !in_run)
    begin
      wd_cnt_d = '0;
    end
    else if (wd_run && tick_rise)
    begin
      wd_cnt_d = wd_cnt_q + 1'b1;
      wd_ovf_d = &wd_cnt_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wd_cnt_q    <= '0;
      wd_ovf_q    <= 1'b0;
      tick_prev_q <= 1'b0;
    end
    else
    begin
      wd_cnt_q    <= wd_cnt_d;
      wd_ovf_q    <= wd_ovf_d;
      tick_prev_q <= presc_tick;
    end
  end

  // interrupt latch and arbitration
  sris_int_arbiter #(
    .NUM_IRQ (NUM_IRQ),
    .VEC_W   (VEC_W)
  ) u_arb (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .irq_req            (irq_req),
    .irq_enable         (int_en_q),
    .global_mask        (global_mask),
    .instr_boundary     (instr_boundary && !internal_reset),
    .ret_done           (ret_done && !internal_reset),
    .soft_req           (soft_req),
    .service_ack        (service_ack),
    .int_take_q         (int_take),
    .vector_q           (int_vector),
    .stack_regs_q       (stack_regs),
    .set_mask_q         (set_mask),
    .stack_index_high_q (stack_index_high),
    .latched_q          (int_latched)
  );

endmodule : sris_top

/* File: test/sris_chk.sv */
// assertions on the sequencer top ports
// assumes a bind from the bench top file; one hclk domain
`timescale 1ns/1ps
module sris_chk
#(
  parameter int VEC_W = 4
)
(
  input logic             hclk,
  input logic             hresetn,
  input logic             bad_opcode_strobe,
  input logic             fetch_is_opcode,
  input logic             fetch_unmapped,
  input logic             soft_req,
  input logic             ret_done,
  input logic             instr_boundary,
  input logic             global_mask,
  input logic             reset_pin_oe,
  input logic             internal_reset,
  input logic             internal_bus_clocks_en,
  input logic             int_take,
  input logic [VEC_W-1:0] int_vector,
  input logic             stack_regs,
  input logic             set_mask,
  input logic             stack_index_high,
  input logic             int_latched
);
  logic [12:0] oe_n_q;
  logic [12:0] oe_n_d;
  logic [12:0] rs_n_q;
  logic [12:0] rs_n_d;
  logic        run;

  // running: out of reset with clocks on
  assign run = !internal_reset && internal_bus_clocks_en;

  always_comb
  begin
    oe_n_d = reset_pin_oe ? oe_n_q + 13'h1 : 13'h0;
    rs_n_d = internal_reset ? rs_n_q + 13'h1 : 13'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      oe_n_q <= 13'h0;
      rs_n_q <= 13'h0;
    end
    else
    begin
      oe_n_q <= oe_n_d;
      rs_n_q <= rs_n_d;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  pin_len_a: assert property ($fell(reset_pin_oe) |-> oe_n_q == 13'h20 || oe_n_q >= 13'h1020)
    else $error("bad pin length");
  rst_len_a: assert property ($fell(internal_reset) |-> rs_n_q == 13'h43 || rs_n_q >= 13'h1040)
    else $error("reset length wrong");
  rst_tail_a: assert property ($fell(reset_pin_oe) |-> internal_reset [*8])
    else $error("reset ended with pin");
  pin_in_rst_a: assert property (reset_pin_oe |-> internal_reset)
    else $error("pin driven outside reset");
  bad_op_a: assert property (bad_opcode_strobe && run |=> internal_reset)
    else $error("no opcode reset");
  bad_fetch_a: assert property (fetch_is_opcode && fetch_unmapped && run |=> internal_reset)
    else $error("no fetch reset");
  swi_take_a: assert property (instr_boundary && soft_req && !int_latched && !internal_reset
    |=> int_take && int_vector == '0 && set_mask && stack_regs)
    else $error("soft irq not taken");
  masked_a: assert property (instr_boundary && global_mask && !soft_req && !ret_done |=> !int_take)
    else $error("masked interrupt taken");
  vec_hold_a: assert property (int_latched && $past(int_latched) |-> $stable(int_vector))
    else $error("latched vector changed");
  entry_a: assert property (int_take |-> int_latched && !stack_index_high)
    else $error("bad interrupt entry");
endmodule : sris_chk

/* File: test/sris_cpu_model.sv */
// cpu side model: instruction boundaries, software interrupt, service ack
// assumes the bench raises run once the core is out of reset
`timescale 1ns/1ps
module sris_cpu_model
(
  input  wire logic hclk,
  input  wire logic run,
  input  wire logic soft_want,
  input  wire logic int_take,
  output logic      instr_boundary,
  output logic      soft_req,
  output logic      ret_done,
  output logic      service_ack
);
  logic [1:0] ph_q;
  logic [1:0] ack_q;

  initial
  begin
    {ph_q, ack_q, instr_boundary, soft_req, ret_done, service_ack} = '0;
  end

  always @(posedge hclk)
  begin
    ph_q           <= ph_q + 2'h1;
    instr_boundary <= run && ph_q == 2'h3;
    soft_req       <= run && ph_q == 2'h3 && soft_want;
    ack_q          <= {ack_q[0], int_take};
    // acknowledge late on purpose so later boundaries hit a held latch
    service_ack    <= ack_q[1];
    ret_done       <= service_ack;
  end
endmodule : sris_cpu_model

/* File: test/sris_top_test.sv */
// self-checking bench for the reset sequencer, watchdog and interrupt latch
// assumes a single ahb-lite master; outputs sampled at the falling edge
`timescale 1ns/1ps
module sris_top_test;
  import sris_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, power_up_reset_pulse, low_voltage_in;
  logic        bad_opcode_strobe, stop_instr_strobe, wake_request, fetch_is_opcode;
  logic        fetch_unmapped, break_active, monitor_mode, global_mask, run, soft_want;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  irq_req;
  logic [3:0]  int_vector;
  logic        hreadyout, reset_pin_out, reset_pin_oe, internal_reset, internal_bus_clocks_en;
  logic        osc_enable, int_take, stack_regs, set_mask, stack_index_high, int_latched;
  logic        instr_boundary, soft_req, ret_done, service_ack;
  wire logic   hready;
  int          n_errors, checked;

  assign hready = hreadyout;
  sris_top #(.WDOG_W(2)) dut (.*);
  sris_cpu_model cpu (.*);

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // sampled at negedge, clear of the launching edge
  task automatic wt(input int s, input logic v, input int lim, output int n);
    logic x;
    n = 0;
    do
    begin
      @(negedge hclk);
      n++;
      case (s)
        0: x = hreadyout;
        1: x = reset_pin_oe;
        2: x = internal_reset;
        3: x = internal_bus_clocks_en;
        default: x = int_take;
      endcase
    end
    while (x !== v && n < lim);
    if (x !== v)
    begin
      n_errors++;
      conclude();
    end
  endtask : wt

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wt(0, 1'b1, 20, n);
    @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wt(0, 1'b1, 20, n);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, e);
  endtask : rd

  task automatic pulse(input int k);
    @(posedge hclk);
    case (k)
      0: bad_opcode_strobe <= 1'b1;
      1: stop_instr_strobe <= 1'b1;
      2: {fetch_is_opcode, fetch_unmapped} <= 2'b11;
      3: fetch_unmapped <= 1'b1;
      default: wake_request <= 1'b1;
    endcase
    @(posedge hclk);
    {bad_opcode_strobe, stop_instr_strobe, fetch_is_opcode, fetch_unmapped, wake_request} <= '0;
  endtask : pulse

  task automatic t_reset;
    int n;
    int m;
    wt(3, 1'b1, 5000, n);
    wt(2, 1'b0, 200, m);
    check(n > 4090 && n < 4100, 1'b1);
    check(n + m > 4158 && n + m < 4168, 1'b1);
    rd(ADDR_CAUSE, 32'h80);
    rd(ADDR_CONTROL, 32'h0);
    rd(8'h20, 32'h0);
    rd(ADDR_STATUS, 32'h10);
  endtask : t_reset

  task automatic t_short(input int k, input logic [31:0] e);
    int n;
    wr(ADDR_CAUSE, 32'hff);
    wr(ADDR_CONTROL, 32'h01);
    pulse(k);
    wt(1, 1'b1, 4, n);
    check({reset_pin_out, hresp}, 3'h0);
    wt(1, 1'b0, 40, n);
    check(n, 32);
    wt(2, 1'b0, 60, n);
    check(n, 35);
    rd(ADDR_CAUSE, e);
  endtask : t_short

  task automatic t_stop(input logic [31:0] c, input int lo, input int hi);
    int n;
    wr(ADDR_CONTROL, c);
    pulse(1);
    @(negedge hclk);
    check({osc_enable, internal_bus_clocks_en}, 2'b00);
    pulse(4);
    wt(3, 1'b1, 5000, n);
    check(n >= lo && n <= hi, 1'b1);
  endtask : t_stop

  task automatic t_irq;
    int n;
    wr(ADDR_INT_EN, 32'h06);
    @(posedge hclk);
    irq_req <= 8'h0e;
    global_mask <= 1'b1;
    run <= 1'b1;
    repeat (12)
    begin
      @(negedge hclk);
      check(int_take, 1'b0);
    end
    @(posedge hclk);
    global_mask <= 1'b0;
    wt(4, 1'b1, 10, n);
    check(int_vector, 4'h2);
    @(posedge hclk);
    irq_req <= 8'h04;
    wt(4, 1'b1, 12, n);
    check(int_vector, 4'h3);
    @(posedge hclk);
    global_mask <= 1'b1;
    soft_want <= 1'b1;
    wt(4, 1'b1, 12, n);
    check(int_vector, 4'h0);
    @(posedge hclk);
    {run, soft_want, irq_req} <= '0;
  endtask : t_irq

  task automatic t_wd(input logic [31:0] c, input logic b, input logic s, input logic [31:0] e);
    wr(ADDR_CAUSE, 32'hff);
    wr(ADDR_CONTROL, c);
    @(posedge hclk);
    {break_active, monitor_mode} <= {b, b};
    repeat (10)
    begin
      repeat (2000) @(negedge hclk);
      if (s) wr(ADDR_SERVICE, 32'h5a);
    end
    rd(ADDR_CAUSE, e);
  endtask : t_wd

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial
  begin
    {hresetn, hsel, hwrite, power_up_reset_pulse, low_voltage_in, bad_opcode_strobe,
     stop_instr_strobe, wake_request, fetch_is_opcode, fetch_unmapped, break_active,
     monitor_mode, global_mask, run, soft_want} = '0;
    {htrans, haddr, hwdata, irq_req} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_short(0, 32'h10);
    t_short(1, 32'h10);
    t_short(2, 32'h08);
    pulse(3);
    repeat (4) @(negedge hclk);
    check(internal_reset, 1'b0);
    t_stop(32'h0a, 30, 36);
    t_stop(32'h08, 4094, 4100);
    t_irq();
    t_wd(32'h11, 1'b0, 1'b0, 32'h20);
    t_wd(32'h11, 1'b0, 1'b1, 32'h0);
    t_wd(32'h15, 1'b1, 1'b0, 32'h0);
    conclude();
  end
endmodule : sris_top_test

bind sris_top sris_chk #(.VEC_W(VEC_W)) u_chk (.*);
